// ===== pll_cfg_pkg.sv
// Function
// [R1] IF feedback divides by B count times prescaler modulus plus A count.
// [R2] Host keeps B at least A; smallest contiguous N is P squared minus P.
// [R3] Control code 000 loads the RF N divider word.
// [R4] Eight-bit RF N field sets the whole_divide_value of the RF feedback.
// [R5] Twelve-bit RF N field loads partial_step_numerator, kept within denominator.
// [R6] Control code 001 loads the RF reference divider word.
// [R7] RF prescaler with integer, fractional, modulus counters sets RF division.
// [R8] Doubler 0 feeds reference straight to R counter; 1 doubles it.
// [R9] Doubler off: falling edge only; doubler on: both edges active.
// [R10] Control code 100 loads the IF N divider word.
// [R11] if_pump_boost forces IF pump current to maximum; clearing restores setting.
// [R12] Four-bit RF reference counter divides reference by 1 to 15.
// [R13] IF word: boost 23, select 22:21, B 20:9, A 8:3, code 2:0.
// [R14] IF select codes 00..11 choose 8/9, 16/17, 32/33, 64/65.
package pll_cfg_pkg;

  // ----------------------------------------------------------------------
  // Control words
  // ----------------------------------------------------------------------
  localparam int WORD_W = 24;
  localparam logic [23:0] WORD_RESET = 24'h000000;
  localparam logic [2:0] CODE_RF_N = 3'h0;
  localparam logic [2:0] CODE_RF_R = 3'h1;
  localparam logic [2:0] CODE_IF_N = 3'h4;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int IF_BOOST_BIT = 23;
  localparam int IF_PSEL_HI = 22;
  localparam int IF_PSEL_LO = 21;
  localparam int IF_B_HI = 20;
  localparam int IF_B_LO = 9;
  localparam int IF_A_HI = 8;
  localparam int IF_A_LO = 3;
  localparam int RF_INT_HI = 22;
  localparam int RF_INT_LO = 15;
  localparam int RF_PARTIAL_STEP_NUMERATOR_HI = 14;
  localparam int RF_PARTIAL_STEP_NUMERATOR_LO = 3;
  localparam int RF_DBL_BIT = 20;
  localparam int RF_PSC_BIT = 19;
  localparam int RF_R_HI = 18;
  localparam int RF_R_LO = 15;
  localparam int RF_MOD_HI = 14;
  localparam int RF_MOD_LO = 3;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL_WORD = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IF_N = 4'h8;
  localparam logic [3:0] ADDR_RF_ACC = 4'hC;

  // ----------------------------------------------------------------------
  // Constants of the dividers and the IF pump current
  // ----------------------------------------------------------------------
  localparam logic [6:0] IF_PSC_BASE = 7'h08;
  localparam logic [2:0] PUMP_MAX = 3'h7;
  localparam logic [2:0] PUMP_RESET = 3'h0;

endpackage

// ===== tick_divider.sv
`timescale 1ns/1ps
module tick_divider #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic restart,
  input wire logic tick,
  input wire logic [W-1:0] ratio,
  output logic pulse
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  wire [W-1:0] one = {{(W-1){1'b0}}, 1'b1};
  // Ratio zero behaves as one so the counter never stalls
  wire [W-1:0] ratio_eff = (ratio == '0) ? one : ratio;
  wire last = (count_reg >= W'(ratio_eff - one));

  assign pulse = tick & last;
  assign count_next = restart ? '0 :
                      !tick ? count_reg :
                      last ? '0 : W'(count_reg + one);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule // tick_divider

// ===== pll_feedback_divider_config.sv
`timescale 1ns/1ps
module pll_feedback_divider_config (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic if_in_tick,
  input wire logic rf_in_tick,
  input wire logic reference_clock_input,
  input wire logic [2:0] if_pump_setting,
  output logic [2:0] if_pump_current,
  output logic if_fb_pulse,
  output logic rf_fb_pulse,
  output logic pfd_ref_pulse,
  output logic rf_prescaler_sel,
  output logic ref_doubler_on
);

  // ----------------------------------------------------------------------
  // Avalon slave
  // ----------------------------------------------------------------------
  // Every access waits exactly one cycle; read data is caught meanwhile
  logic ack_reg;
  logic [31:0] readdata_reg;
  wire req = read | write;
  wire take = req & ~ack_reg;
  wire commit = write & ack_reg;
  assign waitrequest = take;
  assign readdata = readdata_reg;

  wire sel_ctrl = (address == pll_cfg_pkg::ADDR_CTRL_WORD);
  wire sel_status = (address == pll_cfg_pkg::ADDR_STATUS);
  wire sel_if_n = (address == pll_cfg_pkg::ADDR_IF_N);
  wire sel_rf_acc = (address == pll_cfg_pkg::ADDR_RF_ACC);
  // Partial word writes are dropped: a torn control word is worse
  wire word_ok = commit & sel_ctrl & (&byteenable[2:0]);
  wire [2:0] code = writedata[2:0];
  // [R3] RF N routing
  wire load_rf_n = word_ok & (code == pll_cfg_pkg::CODE_RF_N);
  // [R6] RF R routing
  wire load_rf_r = word_ok & (code == pll_cfg_pkg::CODE_RF_R);
  // [R10] IF N routing
  wire load_if = word_ok & (code == pll_cfg_pkg::CODE_IF_N);

  // ----------------------------------------------------------------------
  // Holding registers
  // ----------------------------------------------------------------------
  logic [23:0] if_word_reg;
  logic [23:0] rf_n_word_reg;
  logic [23:0] rf_r_word_reg;
  logic if_loaded_reg;
  logic rf_n_loaded_reg;
  logic rf_r_loaded_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      if_word_reg <= pll_cfg_pkg::WORD_RESET;
      rf_n_word_reg <= pll_cfg_pkg::WORD_RESET;
      rf_r_word_reg <= pll_cfg_pkg::WORD_RESET;
      if_loaded_reg <= 1'b0;
      rf_n_loaded_reg <= 1'b0;
      rf_r_loaded_reg <= 1'b0;
    end else begin
      if (load_if) begin
        if_word_reg <= writedata[23:0];
        if_loaded_reg <= 1'b1;
      end
      if (load_rf_n) begin
        rf_n_word_reg <= writedata[23:0];
        rf_n_loaded_reg <= 1'b1;
      end
      if (load_rf_r) begin
        rf_r_word_reg <= writedata[23:0];
        rf_r_loaded_reg <= 1'b1;
      end
    end
  end

  // [R13] IF field layout
  wire if_pump_boost = if_word_reg[pll_cfg_pkg::IF_BOOST_BIT];
  wire [1:0] if_dual_modulus_select =
    if_word_reg[pll_cfg_pkg::IF_PSEL_HI:pll_cfg_pkg::IF_PSEL_LO];
  wire [11:0] b_val = if_word_reg[pll_cfg_pkg::IF_B_HI:pll_cfg_pkg::IF_B_LO];
  wire [5:0] a_val = if_word_reg[pll_cfg_pkg::IF_A_HI:pll_cfg_pkg::IF_A_LO];
  wire [11:0] b_new = writedata[pll_cfg_pkg::IF_B_HI:pll_cfg_pkg::IF_B_LO];
  wire [5:0] a_new = writedata[pll_cfg_pkg::IF_A_HI:pll_cfg_pkg::IF_A_LO];
  // [R4] Whole divide field
  wire [7:0] whole_divide_value =
    rf_n_word_reg[pll_cfg_pkg::RF_INT_HI:pll_cfg_pkg::RF_INT_LO];
  wire [7:0] int_new = writedata[pll_cfg_pkg::RF_INT_HI:pll_cfg_pkg::RF_INT_LO];
  // [R5] Numerator field
  wire [11:0] partial_step_numerator =
    rf_n_word_reg[pll_cfg_pkg::RF_PARTIAL_STEP_NUMERATOR_HI:pll_cfg_pkg::RF_PARTIAL_STEP_NUMERATOR_LO];
  wire [11:0] interpolator_denominator =
    rf_r_word_reg[pll_cfg_pkg::RF_MOD_HI:pll_cfg_pkg::RF_MOD_LO];
  wire [3:0] r_val = rf_r_word_reg[pll_cfg_pkg::RF_R_HI:pll_cfg_pkg::RF_R_LO];
  wire doubler = rf_r_word_reg[pll_cfg_pkg::RF_DBL_BIT];

  // ----------------------------------------------------------------------
  // IF pulse-swallow divider
  // ----------------------------------------------------------------------
  logic [5:0] a_cnt_reg;
  logic [11:0] b_cnt_reg;
  logic if_dual_modulus_select_out;
  // [R14] Modulus from select code
  wire [6:0] if_p = pll_cfg_pkg::IF_PSC_BASE << if_dual_modulus_select;
  // P+1 while A counts remain, P afterwards
  wire [6:0] if_dual_modulus_select_ratio = if_p + {6'h00, (a_cnt_reg != 6'h00)};
  wire if_tick = if_in_tick & if_loaded_reg;
  // [R1] Cycle ends on the B-th prescaler output
  wire if_fb_strobe = if_dual_modulus_select_out & (b_cnt_reg <= 12'h001);
  wire [17:0] if_n_value = (({6'h00, b_val} << 3) << if_dual_modulus_select)
                           + {12'h000, a_val};

  tick_divider #(.W(7)) u_if_dual_modulus_select (
    .clk(clk),
    .reset(reset),
    .restart(load_if),
    .tick(if_tick),
    .ratio(if_dual_modulus_select_ratio),
    .pulse(if_dual_modulus_select_out)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      a_cnt_reg <= 6'h00;
      b_cnt_reg <= 12'h000;
    end else if (load_if) begin
      a_cnt_reg <= a_new;
      b_cnt_reg <= b_new;
    end else if (if_fb_strobe) begin
      a_cnt_reg <= a_val;
      b_cnt_reg <= b_val;
    end else if (if_dual_modulus_select_out) begin
      a_cnt_reg <= a_cnt_reg - {5'h00, (a_cnt_reg != 6'h00)};
      b_cnt_reg <= b_cnt_reg - 12'h001;
    end
  end

  // ----------------------------------------------------------------------
  // Reference path
  // ----------------------------------------------------------------------
  logic ref_prev_reg;
  logic pfd_strobe;
  wire ref_rise = reference_clock_input & ~ref_prev_reg;
  wire ref_fall = ~reference_clock_input & ref_prev_reg;
  // [R8] [R9] Doubling means taking both edges
  wire ref_tick = rf_r_loaded_reg & (ref_fall | (doubler & ref_rise));

  // [R12] Reference counter
  tick_divider #(.W(4)) u_ref_div (
    .clk(clk),
    .reset(reset),
    .restart(load_rf_r),
    .tick(ref_tick),
    .ratio(r_val),
    .pulse(pfd_strobe)
  );

  // ----------------------------------------------------------------------
  // RF fractional feedback divider
  // ----------------------------------------------------------------------
  logic [8:0] n_cur_reg;
  logic [11:0] acc_reg;
  logic rf_strobe;
  wire [12:0] mod13 = {1'b0, interpolator_denominator};
  wire [12:0] acc_sum = {1'b0, acc_reg} + {1'b0, partial_step_numerator};
  wire mod_zero = (interpolator_denominator == 12'h000);
  wire carry = ~mod_zero & (acc_sum >= mod13);
  wire [12:0] acc_wrap = acc_sum - mod13;
  wire [11:0] acc_next = carry ? acc_wrap[11:0] :
                         mod_zero ? acc_reg : acc_sum[11:0];
  wire [8:0] n_next = {1'b0, whole_divide_value} + {8'h00, carry};

  // [R7] Division counted on the RF input
  tick_divider #(.W(9)) u_rf_div (
    .clk(clk),
    .reset(reset),
    .restart(load_rf_n | load_rf_r),
    .tick(rf_in_tick & rf_n_loaded_reg),
    .ratio(n_cur_reg),
    .pulse(rf_strobe)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      n_cur_reg <= 9'h000;
      acc_reg <= 12'h000;
    end else if (load_rf_n) begin
      n_cur_reg <= {1'b0, int_new};
      acc_reg <= 12'h000;
    end else if (rf_strobe) begin
      // [R5] [R7] Numerator steps the modulus
      n_cur_reg <= n_next;
      acc_reg <= acc_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs and bus state
  // ----------------------------------------------------------------------
  wire [31:0] status_word = {24'h000000, if_pump_current, if_pump_boost,
                             doubler, rf_r_loaded_reg, rf_n_loaded_reg,
                             if_loaded_reg};
  wire [31:0] rd_value = sel_status ? status_word :
                         sel_if_n ? {14'h0000, if_n_value} :
                         sel_rf_acc ? {20'h00000, acc_reg} : 32'h00000000;
  wire [2:0] pump_next = if_pump_boost ? pll_cfg_pkg::PUMP_MAX
                                       : if_pump_setting;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_reg <= 1'b0;
      readdata_reg <= 32'h00000000;
      if_pump_current <= pll_cfg_pkg::PUMP_RESET;
      if_fb_pulse <= 1'b0;
      rf_fb_pulse <= 1'b0;
      pfd_ref_pulse <= 1'b0;
      // False rise after reset is harmless: edges count only once loaded
      ref_prev_reg <= 1'b0;
    end else begin
      ack_reg <= take;
      if (take & read) begin
        readdata_reg <= rd_value;
      end
      // [R11] Boost overrides the setting
      if_pump_current <= pump_next;
      if_fb_pulse <= if_fb_strobe;
      rf_fb_pulse <= rf_strobe;
      pfd_ref_pulse <= pfd_strobe;
      ref_prev_reg <= reference_clock_input;
    end
  end

  assign rf_prescaler_sel = rf_r_word_reg[pll_cfg_pkg::RF_PSC_BIT];
  assign ref_doubler_on = doubler;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [17:0] if_ticks_reg;
  logic if_seen_reg;
  logic [3:0] ref_ticks_reg;
  logic ref_seen_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      if_ticks_reg <= 18'h00000;
      if_seen_reg <= 1'b0;
      ref_ticks_reg <= 4'h0;
      ref_seen_reg <= 1'b0;
    end else begin
      if (load_if) begin
        if_ticks_reg <= 18'h00000;
        if_seen_reg <= 1'b0;
      end else if (if_tick) begin
        if_ticks_reg <= if_fb_strobe ? 18'h00000 : if_ticks_reg + 18'h00001;
        if_seen_reg <= if_seen_reg | if_fb_strobe;
      end
      if (load_rf_r) begin
        ref_ticks_reg <= 4'h0;
        ref_seen_reg <= 1'b0;
      end else if (ref_tick) begin
        ref_ticks_reg <= pfd_strobe ? 4'h0 : ref_ticks_reg + 4'h1;
        ref_seen_reg <= ref_seen_reg | pfd_strobe;
      end
    end
  end

  sequence seq_request_held;
    req && waitrequest;
  endsequence
  sequence seq_answered;
    !waitrequest ##1 (!req || waitrequest);
  endsequence

  chk_bus_answer: assert property (@(posedge clk) disable iff (reset)
    seq_request_held |=> seq_answered)
    else $error("bus request not answered after one wait cycle");

  chk_route_rf_n: assert property (@(posedge clk) disable iff (reset) // [R3]
    load_rf_n |=> rf_n_word_reg == $past(writedata[23:0]) &&
                  if_word_reg == $past(if_word_reg))
    else $error("code 000 word not placed in RF N register");

  chk_route_rf_r: assert property (@(posedge clk) disable iff (reset) // [R6]
    load_rf_r |=> rf_r_word_reg == $past(writedata[23:0]) &&
                  rf_n_word_reg == $past(rf_n_word_reg))
    else $error("code 001 word not placed in RF R register");

  chk_route_if_n: assert property (@(posedge clk) disable iff (reset) // [R10]
    load_if |=> if_word_reg == $past(writedata[23:0]) && if_loaded_reg)
    else $error("code 100 word not placed in IF N register");

  chk_if_ratio: assert property (@(posedge clk) disable iff (reset) // [R1]
    (if_tick && if_fb_strobe && if_seen_reg && b_val >= a_val &&
     b_val != 12'h000) |-> (if_ticks_reg + 18'h00001 == if_n_value))
    else $error("IF feedback period differs from P*B+A");

  chk_if_modulus: assert property (@(posedge clk) disable iff (reset) // [R14]
    if_dual_modulus_select_ratio == ((if_dual_modulus_select == 2'h0) ? 7'h08 :
                       (if_dual_modulus_select == 2'h1) ? 7'h10 :
                       (if_dual_modulus_select == 2'h2) ? 7'h20 : 7'h40)
                      + 7'(a_cnt_reg != 6'h00))
    else $error("IF prescaler modulus wrong for select code");

  chk_pump_boost: assert property (@(posedge clk) disable iff (reset) // [R11]
    ##1 if_pump_current == ($past(if_pump_boost) ? 3'h7
                                                 : $past(if_pump_setting)))
    else $error("IF pump current not forced or restored");

  chk_ref_edges: assert property (@(posedge clk) disable iff (reset) // [R9]
    ref_tick |-> ($fell(reference_clock_input) ||
                  (doubler && $rose(reference_clock_input))))
    else $error("reference edge used against doubler setting");

  chk_ref_ratio: assert property (@(posedge clk) disable iff (reset) // [R12]
    (ref_tick && pfd_strobe && ref_seen_reg && r_val != 4'h0)
      |-> (ref_ticks_reg + 4'h1 == r_val) ##1 pfd_ref_pulse)
    else $error("reference counter period differs from ratio");

  chk_partial_step_numerator_step: assert property (@(posedge clk) disable iff (reset) // [R5]
    (rf_strobe && !load_rf_n && carry)
      |=> n_cur_reg == {1'b0, $past(whole_divide_value)} + 9'h001)
    else $error("fractional carry did not add one to divide value");

endmodule // pll_feedback_divider_config

// ===== avalon_host.sv
`timescale 1ns/1ps
module avalon_host (
  input wire logic clk,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  output logic [3:0] address,
  output logic read,
  output logic write,
  output logic [3:0] byteenable,
  output logic [31:0] writedata,
  output logic rd_valid,
  output logic [31:0] rd_data
);
  initial begin
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'hF;
    writedata = 32'h0;
    rd_valid = 1'b0;
    rd_data = 32'h0;
  end
  function automatic logic [23:0] if_word(input logic bst,
      input logic [1:0] s, input logic [11:0] b, input logic [5:0] a);
    return {bst, s, (b < {6'h00, a}) ? {6'h00, a} : b, a, 3'h4};
  endfunction
  function automatic logic [23:0] rfn_word(input logic [7:0] n,
      input logic [11:0] f, input logic [11:0] m);
    return {1'b0, n, (f > m) ? m : f, 3'h0};
  endfunction
  // Request held until waitrequest is seen low at a rising edge; only the
  // bench timeout ends the wait
  task automatic access(input logic rd, input logic [3:0] a,
      input logic [31:0] d, input logic [3:0] be);
    address <= a;
    read <= rd;
    write <= ~rd;
    byteenable <= be;
    writedata <= d;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    rd_data <= readdata;
    rd_valid <= rd;
    read <= 1'b0;
    write <= 1'b0;
    // One idle edge keeps back-to-back calls from reassigning a strobe
    @(posedge clk);
    rd_valid <= 1'b0;
  endtask
endmodule // avalon_host

// ===== pll_feedback_divider_config_test.sv
`timescale 1ns/1ps
module pll_feedback_divider_config_test;
  logic clk, reset, read, write, rd_valid, waitrequest;
  logic [3:0] address, byteenable;
  logic [31:0] writedata, readdata, rd_data, r, e;
  logic if_in_tick, rf_in_tick, ref_in, if_fb, rf_fb, pfd, psc_sel, dbl_on;
  logic [2:0] pump_set, pump_cur, pl;
  logic [1:0] a;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h00013622;
  logic dl[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic [3:0] rr[4] = '{4'h3, 4'h3, 4'hF, 4'h1};
  int pe[4] = '{24, 12, 60, 8};
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  assign pl = {pfd, rf_fb, if_fb};

  pll_feedback_divider_config dut_u (.clk(clk), .reset(reset),
    .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .if_in_tick(if_in_tick),
    .rf_in_tick(rf_in_tick), .reference_clock_input(ref_in),
    .if_pump_setting(pump_set), .if_pump_current(pump_cur),
    .if_fb_pulse(if_fb), .rf_fb_pulse(rf_fb), .pfd_ref_pulse(pfd),
    .rf_prescaler_sel(psc_sel), .ref_doubler_on(dbl_on));

  avalon_host host_u (.clk(clk), .waitrequest(waitrequest),
    .readdata(readdata), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata),
    .rd_valid(rd_valid), .rd_data(rd_data));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [3:0] ad, input logic [23:0] w,
      input logic [3:0] be);
    host_u.access(1'b0, ad, {8'h00, w}, be);
  endtask

  task automatic rd(input logic [3:0] ad, input logic [31:0] x);
    exp_q.push_back(x);
    host_u.access(1'b1, ad, 32'h0, 4'hF);
  endtask

  // Cycles spanned by k pulses on output s, ticks every cycle
  task automatic span(input int s, input int k, input int x);
    int n, g;
    n = 0;
    g = 0;
    while (pl[s] !== 1'b1 && g < 2000) begin
      @(negedge clk);
      g++;
    end
    repeat (k) begin
      @(negedge clk);
      n++;
      while (pl[s] !== 1'b1 && n < 4000) begin
        @(negedge clk);
        n++;
      end
    end
    check(32'(n), 32'(x));
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------------
  // Read monitor and hang limit
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      end_of_test();
    end
    if (rd_valid === 1'b1 && exp_q.size() != 0) begin
      check(rd_data, exp_q.pop_front());
    end
  end

  // Reference keeps running; its edges are counted only once loaded
  always begin
    repeat (4) @(posedge clk);
    ref_in <= ~ref_in;
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    reset = 1'b1;
    if_in_tick = 1'b0;
    rf_in_tick = 1'b0;
    ref_in = 1'b0;
    pump_set = 3'h0;
    repeat (16) @(posedge clk);
    r = rnd();
    reset <= 1'b0;
    if_in_tick <= 1'b1;
    rf_in_tick <= 1'b1;
    pump_set <= r[2:0];
    @(posedge clk);
    rd(4'h4, {24'h0, r[2:0], 5'h00});
    wr(4'h0, 24'h000002, 4'hF);
    wr(4'h0, host_u.if_word(1'b0, 2'h0, 12'h003, 6'h01), 4'h3);
    wr(4'h8, host_u.if_word(1'b0, 2'h0, 12'h003, 6'h01), 4'hF);
    rd(4'h4, {24'h0, r[2:0], 5'h00});
    rd(4'h8, 32'h0);
    rd(4'h2, 32'h0);
    for (int s = 0; s < 4; s++) begin
      r = rnd();
      a = r[1:0];
      wr(4'h0, host_u.if_word(1'b0, 2'(s), 12'h003, {4'h0, a}), 4'hF);
      e = (32'h8 << s) * 32'h3 + {30'h0, a};
      rd(4'h8, e);
      span(0, 1, int'(e));
    end
    r = rnd();
    pump_set <= r[2:0];
    wr(4'h0, host_u.if_word(1'b1, 2'h0, 12'h003, 6'h01), 4'hF);
    rd(4'h4, {24'h0, 3'h7, 5'h11});
    check({29'h0, pump_cur}, 32'h7);
    wr(4'h0, host_u.if_word(1'b0, 2'h0, 12'h003, 6'h01), 4'hF);
    rd(4'h4, {24'h0, r[2:0], 5'h01});
    check({29'h0, pump_cur}, {29'h0, r[2:0]});
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, {3'h0, dl[i], ~dl[i], rr[i], 12'h000, 3'h1}, 4'hF);
      check({30'h0, dbl_on, psc_sel}, {30'h0, dl[i], ~dl[i]});
      span(2, 1, pe[i]);
    end
    wr(4'h0, host_u.rfn_word(8'h05, 12'h000, 12'h000), 4'hF);
    span(1, 1, 5);
    wr(4'h0, host_u.rfn_word(8'hFF, 12'h000, 12'h000), 4'hF);
    span(1, 1, 255);
    rd(4'hC, 32'h0);
    wr(4'h0, {3'h0, 1'b0, 1'b1, 4'h1, 12'h004, 3'h1}, 4'hF);
    wr(4'h0, host_u.rfn_word(8'h05, 12'h001, 12'h004), 4'hF);
    span(1, 4, 21);
    rd(4'h4, {24'h0, r[2:0], 5'h07});
    repeat (4) @(posedge clk);
    end_of_test();
  end
endmodule // pll_feedback_divider_config_test
